// file: design/crt_pkg.sv
// package: constants and carrier types for the raster timing block
package crt_pkg;
    localparam int CRT_HW = 8;
    localparam int CRT_VW = 12;
    localparam int CRT_AW = 20;
    localparam int CRT_RW = 4;
    localparam logic [3:0] CRT_ADDR_HTIME = 4'h0;
    localparam logic [3:0] CRT_ADDR_HDISP = 4'h1;
    localparam logic [3:0] CRT_ADDR_VTIME = 4'h2;
    localparam logic [3:0] CRT_ADDR_VDISP = 4'h3;
    localparam logic [3:0] CRT_ADDR_CFG = 4'h4;
    localparam logic [3:0] CRT_ADDR_PEN = 4'h5;
    localparam logic [3:0] CRT_ADDR_STAT = 4'h6;
    localparam logic [3:0] CRT_ADDR_BASE = 4'h7;
    localparam logic [7:0] CRT_RST_HTOTAL = 8'h63;
    localparam logic [7:0] CRT_RST_HSW = 8'h08;
    localparam logic [7:0] CRT_RST_HDS = 8'h07;
    localparam logic [7:0] CRT_RST_HDW = 8'h4F;
    localparam logic [11:0] CRT_RST_VTOTAL = 12'h535;
    localparam logic [11:0] CRT_RST_VSW = 12'h02F;
    localparam logic [11:0] CRT_RST_VDS = 12'h063;
    localparam logic [11:0] CRT_RST_VDW = 12'h400;
    localparam logic [7:0] CRT_RCR_MIN_HSW = 8'h03;
    // config bit positions
    localparam int CRT_CFG_PENPOL = 0;
    localparam int CRT_CFG_SLAVE = 1;
    localparam int CRT_CFG_SCROLL2 = 2;
    localparam int CRT_CFG_SYNCPOL = 3;
    localparam int CRT_CFG_GRAPH = 4;
    localparam int CRT_CFG_ZOOM_LO = 8;
    localparam int CRT_CFG_SCRL_LO = 12;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } crt_bus_s;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic csync;
        logic blank;
    } crt_sync_s;

    typedef enum logic [3:0] {
        CRT_H_SYNC = 4'h1,
        CRT_H_BACK = 4'h2,
        CRT_H_DISP = 4'h4,
        CRT_H_FRONT = 4'h8
    } crt_hphase_e;
endpackage

// file: design/crt_raster_timing.sv
// raster timing generator with light pen latch, sync master/slave and scroll mode
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - horizontal counts run in video memory cycles, one per mem_cycle tick
// - vertical counts run in scan lines, one per completed line
// - sync width in cycles; raster count reads valid only above three
// - front porch is whatever remains of the line total
// - light pen strobe latches refresh address plus character/graphics bit
// - light pen strobe polarity chosen by a static configuration bit
// - up to three boards: one master, the rest slaves
// - configuration picks internal pixel clock for master, external for slave
// - mode one: scroll and zoom together; mode two: scroll only unzoomed
// - composite sync mixed on video, separate sync output with selectable polarity
module crt_raster_timing
    import crt_pkg::*;
#(
    parameter int HW = CRT_HW,
    parameter int VW = CRT_VW,
    parameter int AW = CRT_AW
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // video memory cycle tick
    input wire logic mem_cycle,
    // pins from outside
    input wire logic light_pen,
    input wire logic ext_sync_n,
    // monitor side
    output crt_sync_s sync_out,
    output logic video_sync_mix,
    output logic sep_csync,
    output logic [AW-1:0] refresh_addr,
    output logic [3:0] scroll_dot,
    output logic pixel_clk_ext_sel,
    output logic master_sync_drive
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [HW-1:0] line_cycle_total;
    logic [HW-1:0] hsync_width;
    logic [HW-1:0] hdisplay_start;
    logic [HW-1:0] hdisplay_width;
    logic [VW-1:0] vtotal;
    logic [VW-1:0] vsync_width;
    logic [VW-1:0] vdisp_start;
    logic [VW-1:0] vdisp_width;
    logic [15:0] cfg;
    logic [AW-1:0] base_addr;
    logic [AW:0] pen_latch;
    logic pen_valid;
    logic [15:0] rdata_q;

    crt_bus_s bus;
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    wire pen_pol_neg = cfg[CRT_CFG_PENPOL];
    wire is_slave = cfg[CRT_CFG_SLAVE];
    wire scroll_mode2 = cfg[CRT_CFG_SCROLL2];
    wire sync_polarity_select = cfg[CRT_CFG_SYNCPOL];
    wire graph_screen = cfg[CRT_CFG_GRAPH];
    wire [3:0] zoom = cfg[CRT_CFG_ZOOM_LO +: 4];
    wire [3:0] scroll_req = cfg[CRT_CFG_SCRL_LO +: 4];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    logic pen_s1, pen_s2, pen_s3;
    logic exs_s1, exs_s2, exs_s3;

    always_ff @(posedge clk) begin
        pen_s1 <= light_pen;
        pen_s2 <= pen_s1;
        pen_s3 <= pen_s2;
        exs_s1 <= ext_sync_n;
        exs_s2 <= exs_s1;
        exs_s3 <= exs_s2;
    end

    wire pen_lvl = pen_s2 ^ pen_pol_neg;
    wire pen_lvl_d = pen_s3 ^ pen_pol_neg;
    wire pen_strobe = pen_lvl & ~pen_lvl_d;
    // slave restarts its frame on the falling edge of the master's sync
    wire ext_frame_start = is_slave & exs_s3 & ~exs_s2;

    ////////////////////////////////////////////////////////////////////////////
    // horizontal counter and phase
    logic [HW-1:0] hcnt;
    crt_hphase_e hphase;
    crt_hphase_e next_hphase;
    logic [VW-1:0] vcnt;

    // inclusive end counts; fields hold minus-one values where noted
    wire [HW-1:0] sync_end = hsync_width - HW'(1);
    wire [HW-1:0] back_end = sync_end + hdisplay_start + HW'(1);
    wire [HW-1:0] disp_end = back_end + hdisplay_width + HW'(1);
    // at or past the total, so a shortened line cannot run the counter to wrap
    wire line_end = (hcnt >= line_cycle_total);
    wire [HW:0] used_cnt = {1'b0, disp_end} + (HW+1)'(1);
    // a line too short for its fields simply ends at the total, cutting short whichever phase is running
    wire has_front = ({1'b0, line_cycle_total} >= used_cnt);

    always_comb begin
        next_hphase = hphase;
        unique case (hphase)
            CRT_H_SYNC: if (hcnt == sync_end) next_hphase = CRT_H_BACK;
            CRT_H_BACK: if (hcnt == back_end) next_hphase = CRT_H_DISP;
            CRT_H_DISP: if (hcnt == disp_end) next_hphase = CRT_H_FRONT;
            CRT_H_FRONT: next_hphase = hphase;
            default: next_hphase = CRT_H_SYNC;
        endcase
        if (line_end) begin
            next_hphase = CRT_H_SYNC;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || ext_frame_start) begin
            hcnt <= '0;
            hphase <= CRT_H_SYNC;
        end else if (mem_cycle) begin
            hcnt <= line_end ? '0 : hcnt + HW'(1);
            hphase <= next_hphase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // vertical counter in lines
    wire v_end = (vcnt >= vtotal);
    always_ff @(posedge clk) begin
        if (sys_rst || ext_frame_start) begin
            vcnt <= '0;
        end else if (mem_cycle && line_end) begin
            vcnt <= v_end ? '0 : vcnt + VW'(1);
        end
    end

    wire v_sync = (vcnt < vsync_width);
    wire v_disp = (vcnt > vsync_width + vdisp_start) &&
                  (vcnt <= vsync_width + vdisp_start + vdisp_width);
    wire h_disp = (hphase == CRT_H_DISP);
    wire front_ok = has_front | (hphase != CRT_H_FRONT);

    ////////////////////////////////////////////////////////////////////////////
    // refresh address, scroll and zoom
    logic [AW-1:0] addr_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_q <= '0;
        end else if (mem_cycle && h_disp && v_disp) begin
            addr_q <= addr_q + AW'(1);
        end else if (mem_cycle && line_end && v_end) begin
            addr_q <= base_addr;
        end
    end

    // mode two blocks smooth scroll whenever magnification is on
    wire scroll_ok = ~scroll_mode2 | (zoom == 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // sync outputs
    logic hs_q, vs_q, cs_q, blank_q, sep_q, mix_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_q <= 1'b0;
            vs_q <= 1'b0;
            cs_q <= 1'b0;
            blank_q <= 1'b1;
            sep_q <= 1'b0;
            mix_q <= 1'b0;
        end else begin
            hs_q <= (hphase == CRT_H_SYNC);
            vs_q <= v_sync;
            cs_q <= (hphase == CRT_H_SYNC) ^ v_sync;
            blank_q <= ~(h_disp & v_disp & front_ok);
            sep_q <= ((hphase == CRT_H_SYNC) ^ v_sync) ^ sync_polarity_select;
            mix_q <= (hphase == CRT_H_SYNC) ^ v_sync;
        end
    end

    assign sync_out = '{hsync: hs_q, vsync: vs_q, csync: cs_q, blank: blank_q};
    assign sep_csync = sep_q;
    assign video_sync_mix = mix_q;
    assign refresh_addr = addr_q;
    assign pixel_clk_ext_sel = is_slave;
    assign master_sync_drive = ~is_slave;

    logic [3:0] scroll_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scroll_q <= '0;
        end else begin
            scroll_q <= scroll_ok ? scroll_req : 4'h0;
        end
    end
    assign scroll_dot = scroll_q;

    ////////////////////////////////////////////////////////////////////////////
    // light pen latch; a new strobe wins over the read that clears valid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pen_latch <= '0;
            pen_valid <= 1'b0;
        end else if (pen_strobe) begin
            pen_latch <= {graph_screen, addr_q};
            pen_valid <= 1'b1;
        end else if (bus.rd && bus.addr == CRT_ADDR_PEN) begin
            pen_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_cycle_total <= CRT_RST_HTOTAL;
            hsync_width <= CRT_RST_HSW;
            hdisplay_start <= CRT_RST_HDS;
            hdisplay_width <= CRT_RST_HDW;
            vtotal <= CRT_RST_VTOTAL;
            vsync_width <= CRT_RST_VSW;
            vdisp_start <= CRT_RST_VDS;
            vdisp_width <= CRT_RST_VDW;
            cfg <= '0;
            base_addr <= '0;
        end else if (bus.wr) begin
            unique case (bus.addr)
                CRT_ADDR_HTIME: begin
                    line_cycle_total <= bus.wdata[15:8];
                    hsync_width <= bus.wdata[7:0];
                end
                CRT_ADDR_HDISP: begin
                    hdisplay_start <= bus.wdata[15:8];
                    hdisplay_width <= bus.wdata[7:0];
                end
                CRT_ADDR_VTIME: vtotal <= bus.wdata[VW-1:0];
                CRT_ADDR_VDISP: begin
                    vdisp_start <= VW'(bus.wdata[15:8]);
                    vsync_width <= VW'(bus.wdata[7:0]);
                end
                CRT_ADDR_CFG: cfg <= bus.wdata;
                CRT_ADDR_BASE: base_addr <= AW'(bus.wdata);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads, data one cycle after the strobe
    wire raster_readable = (hsync_width > CRT_RCR_MIN_HSW);
    wire [15:0] raster_count_reg = raster_readable ? {4'h0, vcnt} : 16'h0000;
    wire [15:0] rd_mux =
        (bus.addr == CRT_ADDR_HTIME) ? {line_cycle_total, hsync_width} :
        (bus.addr == CRT_ADDR_HDISP) ? {hdisplay_start, hdisplay_width} :
        (bus.addr == CRT_ADDR_VTIME) ? {4'h0, vtotal} :
        (bus.addr == CRT_ADDR_VDISP) ? {vdisp_start[7:0], vsync_width[7:0]} :
        (bus.addr == CRT_ADDR_CFG) ? cfg :
        (bus.addr == CRT_ADDR_PEN) ? {pen_valid, pen_latch[AW], 14'h0000} | 16'h0000 :
        (bus.addr == CRT_ADDR_STAT) ? raster_count_reg :
        (bus.addr == CRT_ADDR_BASE) ? base_addr[15:0] : 16'h0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= bus.rd ? rd_mux : 16'h0000;
        end
    end
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_hcnt_bound;
        @(posedge clk) disable iff (sys_rst)
            (mem_cycle && hcnt > line_cycle_total) |=> hcnt == '0;
    endproperty
    a_hcnt_bound: assert property (p_hcnt_bound) else $error("hcnt past total");

    property p_wrap;
        @(posedge clk) disable iff (sys_rst)
            (mem_cycle && line_end && !ext_frame_start) |=> (hcnt == '0 && hphase == CRT_H_SYNC);
    endproperty
    a_wrap: assert property (p_wrap) else $error("line did not restart");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
            (!mem_cycle && !ext_frame_start) |=> $stable(hcnt);
    endproperty
    a_hold: assert property (p_hold) else $error("hcnt moved without cycle");

    property p_vstep;
        @(posedge clk) disable iff (sys_rst)
            (!(mem_cycle && line_end) && !ext_frame_start) |=> $stable(vcnt);
    endproperty
    a_vstep: assert property (p_vstep) else $error("vcnt moved mid line");

    property p_pen;
        @(posedge clk) disable iff (sys_rst)
            pen_strobe |=> (pen_valid && pen_latch == {$past(graph_screen), $past(addr_q)});
    endproperty
    a_pen: assert property (p_pen) else $error("pen not latched");

    property p_sep_pol;
        @(posedge clk) disable iff (sys_rst) ##1 sep_csync == (mix_q ^ $past(sync_polarity_select));
    endproperty
    a_sep_pol: assert property (p_sep_pol) else $error("sync polarity wrong");

    property p_scroll;
        @(posedge clk) disable iff (sys_rst)
            (scroll_mode2 && zoom != 4'h0) |=> scroll_dot == 4'h0;
    endproperty
    a_scroll: assert property (p_scroll) else $error("scroll under zoom");

    property p_rcr;
        @(posedge clk) disable iff (sys_rst)
            (bus.rd && bus.addr == CRT_ADDR_STAT && hsync_width <= CRT_RCR_MIN_HSW)
                |=> reg_rdata == 16'h0000;
    endproperty
    a_rcr: assert property (p_rcr) else $error("raster count readable");

    property p_clk_sel;
        @(posedge clk) disable iff (sys_rst) pixel_clk_ext_sel != master_sync_drive;
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("clock source mismatch");

    property p_vwrap;
        @(posedge clk) disable iff (sys_rst)
            (mem_cycle && line_end && v_end) |=> vcnt == '0;
    endproperty
    a_vwrap: assert property (p_vwrap) else $error("frame did not wrap");

    property p_front_blank;
        @(posedge clk) disable iff (sys_rst)
            (hphase == CRT_H_FRONT) |=> sync_out.blank;
    endproperty
    a_front_blank: assert property (p_front_blank) else $error("front porch not blanked");

endmodule // crt_raster_timing

// file: verif/crt_far_side.sv
// far side model: light pen and the sync line of a master board
`timescale 1ns/100ps
module crt_far_side (
    // clock
    input wire logic clk,
    // pins toward the board
    output logic light_pen,
    output logic ext_sync_n
);
    initial begin
        light_pen = 1'b0;
        ext_sync_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // settle at the idle level first; held 3 clocks so the synchroniser sees it
    task automatic pen_pulse(input logic neg);
        @(posedge clk);
        light_pen <= neg;
        repeat (4) @(posedge clk);
        light_pen <= ~neg;
        repeat (3) @(posedge clk);
        light_pen <= neg;
        repeat (4) @(posedge clk);
    endtask
    // only one master ever drives this line; idle high like a pulled-up pin
    task automatic master_sync;
        @(posedge clk);
        ext_sync_n <= 1'b0;
        repeat (3) @(posedge clk);
        ext_sync_n <= 1'b1;
    endtask
endmodule // crt_far_side

// file: verif/tb_top.sv
// self-checking bench for the raster timing block
`timescale 1ns/100ps
module tb_top;
    import crt_pkg::*;
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [15:0] wdata;
        logic [15:0] exp;
    } crt_row_s;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic mem_cycle = 1'b0;
    logic [15:0] reg_rdata;
    crt_sync_s sync_out;
    logic video_sync_mix;
    logic sep_csync;
    logic [19:0] refresh_addr;
    logic [3:0] scroll_dot;
    logic pixel_clk_ext_sel;
    logic master_sync_drive;
    logic light_pen;
    logic ext_sync_n;
    int bad_count = 0;
    int num_checks = 0;
    int n;
    logic [15:0] rd;
    crt_row_s rows [10];

    crt_raster_timing DUT (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_cycle(mem_cycle),
        .light_pen(light_pen), .ext_sync_n(ext_sync_n), .sync_out(sync_out),
        .video_sync_mix(video_sync_mix), .sep_csync(sep_csync),
        .refresh_addr(refresh_addr), .scroll_dot(scroll_dot),
        .pixel_clk_ext_sel(pixel_clk_ext_sel), .master_sync_drive(master_sync_drive)
    );
    crt_far_side far (.clk(clk), .light_pen(light_pen), .ext_sync_n(ext_sync_n));

    always #25 clk = ~clk;
    // one memory cycle every two clocks, so every count below is doubled
    always @(posedge clk) mem_cycle <= ~mem_cycle;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return sync_out.hsync;
            1: return sync_out.blank;
            default: return sync_out.vsync;
        endcase
    endfunction
    // capped so that a stuck line cannot hang the run
    task automatic wait_for(input int sel, input logic v, output int cnt);
        cnt = 0;
        while (pick(sel) !== v && cnt < 5000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (pick(sel) !== v) begin
            bad_count++;
        end
    endtask
    task automatic scroll_case(input logic [15:0] cfg, input logic [3:0] exp);
        reg_write(CRT_ADDR_CFG, cfg);
        repeat (3) @(posedge clk);
        check(scroll_dot, exp);
    endtask
    task automatic sync_try(input logic [15:0] cfg, input logic slave);
        reg_write(CRT_ADDR_CFG, cfg);
        repeat (2) @(posedge clk);
        check(pixel_clk_ext_sel, slave);
        check(master_sync_drive, !slave);
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
        repeat (6) @(posedge clk);
        far.master_sync();
        wait_for(0, 1'b1, n);
        check(n <= 10, slave);
    endtask
    task automatic end_sim;
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(50 * 40000);
        bad_count++;
        end_sim();
    end
    initial begin
        // 20 cycles per line (even), sync 4, back porch 2, display 10, front 4
        rows = '{{1'b0, 4'h0, 16'h0000, 16'h6308}, {1'b0, 4'h1, 16'h0000, 16'h074F},
                 {1'b0, 4'h2, 16'h0000, 16'h0535}, {1'b0, 4'h3, 16'h0000, 16'h632F},
                 {1'b0, 4'h4, 16'h0000, 16'h0000}, {1'b1, 4'h0, 16'h1304, 16'h1304},
                 {1'b1, 4'h1, 16'h0109, 16'h0109}, {1'b1, 4'h2, 16'h0010, 16'h0010},
                 {1'b1, 4'h3, 16'h0102, 16'h0102}, {1'b1, 4'h8, 16'hFFFF, 16'h0000}};
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                reg_write(rows[i].addr, rows[i].wdata);
            end
            reg_read(rows[i].addr, rd);
            check(rd, rows[i].exp);
        end
        // line phases, measured in a displayed line
        wait_for(2, 1'b1, n);
        wait_for(2, 1'b0, n);
        wait_for(1, 1'b0, n);
        wait_for(1, 1'b1, n);
        wait_for(0, 1'b1, n);
        check(n, 8);
        wait_for(0, 1'b0, n);
        check(n, 8);
        wait_for(1, 1'b0, n);
        check(n, 4);
        wait_for(1, 1'b1, n);
        check(n, 20);
        wait_for(2, 1'b1, n);
        wait_for(2, 1'b0, n);
        check(n, 80);
        // raster count hidden while the sync is three cycles or less
        reg_write(CRT_ADDR_HTIME, 16'h1303);
        reg_read(CRT_ADDR_STAT, rd);
        check(rd, 16'h0000);
        reg_write(CRT_ADDR_HTIME, 16'h1304);
        wait_for(1, 1'b0, n);
        reg_read(CRT_ADDR_STAT, rd);
        check(rd != 16'h0000, 1'b1);
        // light pen, both polarities; a read consumes the capture
        far.pen_pulse(1'b0);
        reg_read(CRT_ADDR_PEN, rd);
        check(rd, 16'h8000);
        reg_read(CRT_ADDR_PEN, rd);
        check(rd, 16'h0000);
        reg_write(CRT_ADDR_CFG, 16'h0011);
        far.pen_pulse(1'b1);
        reg_read(CRT_ADDR_PEN, rd);
        check(rd, 16'hC000);
        scroll_case(16'h5301, 4'h5);
        scroll_case(16'h5305, 4'h0);
        scroll_case(16'h5005, 4'h5);
        sync_try(16'h0003, 1'b1);
        sync_try(16'h0001, 1'b0);
        for (int p = 0; p < 2; p++) begin
            reg_write(CRT_ADDR_CFG, p[0] ? 16'h0009 : 16'h0001);
            wait_for(0, 1'b1, n);
            repeat (4) @(posedge clk);
            #1;
            check(sep_csync, sync_out.csync ^ p[0]);
            check(video_sync_mix, sync_out.hsync ^ sync_out.vsync);
        end
        // refresh address reloads from base at frame wrap, one step per display cycle
        reg_write(CRT_ADDR_BASE, 16'h0120);
        wait_for(2, 1'b1, n);
        wait_for(2, 1'b0, n);
        wait_for(2, 1'b1, n);
        check(refresh_addr, 20'h00120);
        wait_for(1, 1'b0, n);
        wait_for(1, 1'b1, n);
        check(refresh_addr, 20'h0012A);
        // second reset in mid-run
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(sync_out.blank, 1'b1);
        check(reg_rdata, 16'h0000);
        @(posedge clk);
        sys_rst <= 1'b0;
        reg_read(CRT_ADDR_HTIME, rd);
        check(rd, 16'h6308);
        end_sim();
    end
endmodule // tb_top
